// *** verilog/udc_ctrl_regs.sv ***
// usb device control registers: event flags, address, configuration, line override
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - ones at 31,29,26 clear reset/resume/sof
// - ones at 24..19 clear endpoint0 flags
// - bit 18,17 clear setup error, timeout
// - bits 11..8 clear endpoint 4..1 ack
// - bits 3..0 clear endpoint 4..1 nak
// - seven-bit address, resets zero, upper zero
// - regulator enable bit resets one, cfg output resets zero, else core
// - transceiver on, forced off in sleep
// - bit 29 drives d+ pull-up
// - bit 28 enables serial engine
// - bit 27 enables line protection
// - bit 26 connects both pull-downs
// - direction bits: zero in, one out
// - drive bit gates bus and writes
// - driven lines follow d+ d- bits
// - se0 over 2.5 us sets reset
// - idle over 3 ms sets suspend
module udc_ctrl_regs
    import udc_pkg::*;
#(
    parameter int RESET_CYC   = UDC_RESET_CYC,
    parameter int SUSPEND_CYC = UDC_SUSPEND_CYC
) (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output var  logic [31:0] regRdata,
    output var  logic        irq,
    input  wire logic        lineDp,
    input  wire logic        lineDm,
    input  wire logic        lowPower,
    input  wire logic        evResume,
    input  wire logic        evSof,
    input  wire logic [5:0]  evEp0,
    input  wire logic        evSetupErr,
    input  wire logic        evTimeout,
    input  wire logic [3:0]  evAck,
    input  wire logic [3:0]  evNak,
    input  wire logic        epInToken,
    input  wire logic        epOutToken,
    input  wire logic [1:0]  epTokenNum,
    output var  logic        epHandshakeOk,
    output var  logic [6:0]  functionAddress,
    output var  udc_cfg_t    cfg,
    output var  udc_line_t   lineOut,
    output var  logic        dpOut,
    output var  logic        dpOe,
    output var  logic        dmOut,
    output var  logic        dmOe
);
    logic [31:0] status;
    logic [31:0] mask;
    logic [31:0] eventVec;
    logic [31:0] clearVec;
    logic [6:0]  addrReg;
    logic [31:0] cfgReg;
    logic [2:0]  lineReg;
    logic        busResetPulse;
    logic        suspendPulse;
    logic        se0;
    logic        idleJ;
    logic        wrClear;
    logic [31:0] next_rdata;

    assign se0 = !lineDp && !lineDm;
    // full speed idle is j: d+ high, d- low
    assign idleJ = lineDp && !lineDm;
    assign wrClear = regWrite && (regAddr == UDC_OFF_CLEAR);

    udc_line_timer #(.LIMIT(RESET_CYC)) uResetTimer (
        .mclk  (mclk),
        .rst_n (rst_n),
        .cond  (se0),
        .fire  (busResetPulse)
    );

    udc_line_timer #(.LIMIT(SUSPEND_CYC)) uSuspendTimer (
        .mclk  (mclk),
        .rst_n (rst_n),
        .cond  (idleJ),
        .fire  (suspendPulse)
    );

    always_comb begin
        eventVec = '0;
        eventVec[UDC_BIT_RESET]   = busResetPulse;
        eventVec[UDC_BIT_SUSPEND] = suspendPulse;
        eventVec[UDC_BIT_RESUME]  = evResume;
        eventVec[UDC_BIT_SOF]     = evSof;
        eventVec[UDC_BIT_EP0_LO +: 6] = evEp0;
        eventVec[UDC_BIT_ERR_SET] = evSetupErr;
        eventVec[UDC_BIT_ERR_TO]  = evTimeout;
        eventVec[UDC_BIT_ACK_LO +: UDC_NUM_EP] = evAck;
        eventVec[UDC_BIT_NAK_LO +: UDC_NUM_EP] = evNak;
    end

    // only documented clear bits act; zeros and reserved bits do nothing
    assign clearVec = (wrClear ? regWdata : 32'h00000000) & UDC_CLEAR_MASK;

    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++) begin : gFlag
            if (UDC_EVENT_MASK[gi]) begin : gLive
                udc_flag_bit uFlag (
                    .mclk     (mclk),
                    .rst_n    (rst_n),
                    .setEvent (eventVec[gi]),
                    .clearReq (clearVec[gi]),
                    .flag     (status[gi])
                );
            end else begin : gDead
                assign status[gi] = 1'b0;
            end
        end
    endgenerate

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mask <= '0;
        end else if (regWrite && regAddr == UDC_OFF_MASK) begin
            mask <= regWdata & UDC_EVENT_MASK;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status & mask);
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            addrReg <= UDC_ADDR_RESET;
        end else if (regWrite && regAddr == UDC_OFF_ADDR) begin
            addrReg <= regWdata[6:0];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cfgReg <= UDC_CFG_RESET;
        end else if (regWrite && regAddr == UDC_OFF_CFG) begin
            cfgReg <= regWdata & UDC_CFG_WMASK;
        end
    end

    // d+/d- bits take writes only while driving is enabled by that same write or was already enabled
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            lineReg <= '0;
        end else if (regWrite && regAddr == UDC_OFF_LINE) begin
            lineReg[UDC_LINE_DRV] <= regWdata[UDC_LINE_DRV];
            if (regWdata[UDC_LINE_DRV] || lineReg[UDC_LINE_DRV]) begin
                lineReg[UDC_LINE_DP] <= regWdata[UDC_LINE_DP];
                lineReg[UDC_LINE_DM] <= regWdata[UDC_LINE_DM];
            end
        end
    end

    always_comb begin
        unique case (regAddr)
            UDC_OFF_STATUS: next_rdata = status;
            UDC_OFF_ADDR:   next_rdata = {25'h0000000, addrReg};
            UDC_OFF_CFG:    next_rdata = cfgReg;
            UDC_OFF_LINE:   next_rdata = {29'h00000000, lineReg};
            UDC_OFF_MASK:   next_rdata = mask;
            // clear register is write-only; unmapped reads give zero
            default:        next_rdata = 32'h00000000;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            regRdata <= '0;
        end else if (regRead) begin
            regRdata <= next_rdata;
        end else begin
            regRdata <= '0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            functionAddress <= UDC_ADDR_RESET;
            cfg             <= '0;
        end else begin
            functionAddress <= addrReg;
            cfg.regulator_enable     <= cfgReg[UDC_CFG_VREG];
            cfg.transceiver_enable   <= cfgReg[UDC_CFG_PHY] && !lowPower;
            cfg.dplus_pullup_enable  <= cfgReg[UDC_CFG_PULLUP];
            cfg.serial_engine_enable <= cfgReg[UDC_CFG_SIE];
            cfg.line_protect_enable  <= cfgReg[UDC_CFG_ESD];
            cfg.line_pulldown_enable <= cfgReg[UDC_CFG_PULLDN];
            cfg.endpoint_direction   <= cfgReg[UDC_NUM_EP-1:0];
        end
    end

    // token number 0..3 means endpoint 1..4
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            epHandshakeOk <= 1'b0;
        end else begin
            epHandshakeOk <= cfgReg[epTokenNum] ? epOutToken : epInToken;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            lineOut <= '0;
            dpOut   <= 1'b0;
            dpOe    <= 1'b0;
            dmOut   <= 1'b0;
            dmOe    <= 1'b0;
        end else begin
            lineOut <= lineReg;
            dpOe    <= lineReg[UDC_LINE_DRV];
            dmOe    <= lineReg[UDC_LINE_DRV];
            dpOut   <= lineReg[UDC_LINE_DRV] && lineReg[UDC_LINE_DP];
            dmOut   <= lineReg[UDC_LINE_DRV] && lineReg[UDC_LINE_DM];
        end
    end
endmodule
`default_nettype wire

// *** inc/udc_pkg.sv ***
// package: register map, field positions, reset values, timing counts for the usb device control block
package udc_pkg;

    localparam logic [7:0]  UDC_OFF_STATUS  = 8'h04;
    localparam logic [7:0]  UDC_OFF_CLEAR   = 8'h08;
    localparam logic [7:0]  UDC_OFF_ADDR    = 8'h0c;
    localparam logic [7:0]  UDC_OFF_CFG     = 8'h10;
    localparam logic [7:0]  UDC_OFF_LINE    = 8'h14;
    localparam logic [7:0]  UDC_OFF_MASK    = 8'h1c;

    localparam int          UDC_BIT_RESET   = 31;
    localparam int          UDC_BIT_SUSPEND = 30;
    localparam int          UDC_BIT_RESUME  = 29;
    localparam int          UDC_BIT_SOF     = 26;
    localparam int          UDC_BIT_EP0_LO  = 19;
    localparam int          UDC_BIT_ERR_SET = 18;
    localparam int          UDC_BIT_ERR_TO  = 17;
    localparam int          UDC_BIT_ACK_LO  = 8;
    localparam int          UDC_BIT_NAK_LO  = 0;
    localparam int          UDC_NUM_EP      = 4;

    // bits that events may set; the rest of the status word reads zero
    localparam logic [31:0] UDC_EVENT_MASK  = 32'he5fe0f0f;
    // suspend has no clear bit
    localparam logic [31:0] UDC_CLEAR_MASK  = 32'ha5fe0f0f;

    localparam int          UDC_CFG_VREG    = 31;
    localparam int          UDC_CFG_PHY     = 30;
    localparam int          UDC_CFG_PULLUP  = 29;
    localparam int          UDC_CFG_SIE     = 28;
    localparam int          UDC_CFG_ESD     = 27;
    localparam int          UDC_CFG_PULLDN  = 26;
    localparam logic [31:0] UDC_CFG_WMASK   = 32'hfc00000f;
    localparam logic [31:0] UDC_CFG_RESET   = 32'h80000000;
    localparam logic [6:0]  UDC_ADDR_RESET  = 7'h00;

    localparam int          UDC_LINE_DRV    = 2;
    localparam int          UDC_LINE_DP     = 1;
    localparam int          UDC_LINE_DM     = 0;

    localparam real         UDC_CLK_NS      = 8.0;
    localparam real         UDC_RESET_NS    = 2500.0;
    localparam real         UDC_SUSPEND_NS  = 3000000.0;
    // more than 2.5 us of se0: least time, round up
    localparam int          UDC_RESET_CYC   = int'($ceil(UDC_RESET_NS / UDC_CLK_NS));
    localparam int          UDC_SUSPEND_CYC = int'($ceil(UDC_SUSPEND_NS / UDC_CLK_NS));

    typedef struct packed {
        logic       drive;
        logic       dplus;
        logic       dminus;
    } udc_line_t;

    typedef struct packed {
        logic       regulator_enable;
        logic       transceiver_enable;
        logic       dplus_pullup_enable;
        logic       serial_engine_enable;
        logic       line_protect_enable;
        logic       line_pulldown_enable;
        logic [3:0] endpoint_direction;
    } udc_cfg_t;

endpackage

// *** verilog/udc_line_timer.sv ***
// line timer: counts a held bus condition and pulses once when it exceeds a limit
`timescale 1ns/1ps
`default_nettype none
module udc_line_timer #(
    parameter int LIMIT = 313
) (
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic cond,
    output var  logic fire
);
    localparam int W = $clog2(LIMIT + 2);
    localparam logic [W-1:0] LIM = W'(LIMIT);

    logic [W-1:0] count;

    // saturates so a long condition gives a single pulse
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
        end else if (!cond) begin
            count <= '0;
        end else if (count <= LIM) begin
            count <= count + W'(1);
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fire <= 1'b0;
        end else begin
            fire <= cond && (count == LIM);
        end
    end
endmodule
`default_nettype wire

// *** verilog/udc_flag_bit.sv ***
// sticky event flag with write-one-to-clear, set beating clear
`timescale 1ns/1ps
`default_nettype none
module udc_flag_bit (
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic setEvent,
    input  wire logic clearReq,
    output var  logic flag
);
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            flag <= 1'b0;
        end else if (setEvent) begin
            flag <= 1'b1;
        end else if (clearReq) begin
            flag <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** verification/udc_host_model.sv ***
// host stand-in: drives the d+/d- line states that the device sees
`timescale 1ns/1ps
`default_nettype none
module udc_host_model (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic [1:0] mode,
    output var  logic       dp,
    output var  logic       dm
);
    logic phase;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            phase <= 1'b0;
        end else begin
            phase <= ~phase;
        end
    end
    // traffic swaps j and k each cycle, so neither idle nor se0 lasts
    always_comb begin
        case (mode)
            2'd1: {dp, dm} = 2'b10;
            2'd2: {dp, dm} = 2'b00;
            default: {dp, dm} = {phase, ~phase};
        endcase
    end
endmodule
`default_nettype wire

// *** verification/udc_ctrl_regs_monitor.sv ***
// checker: readback, sleep, handshake and line-drive relations
`timescale 1ns/1ps
`default_nettype none
module udc_ctrl_regs_monitor
    import udc_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic [7:0]  regAddr,
    input wire logic        regRead,
    input wire logic [31:0] regRdata,
    input wire logic        lowPower,
    input wire logic        epInToken,
    input wire logic        epOutToken,
    input wire logic [1:0]  epTokenNum,
    input wire logic        epHandshakeOk,
    input wire logic [6:0]  functionAddress,
    input wire udc_cfg_t    cfg,
    input wire udc_line_t   lineOut,
    input wire logic        dpOut,
    input wire logic        dpOe,
    input wire logic        dmOut,
    input wire logic        dmOe
);
    logic dirSel;
    assign dirSel = cfg.endpoint_direction[epTokenNum];
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_addr_readback: assert property (regRead && regAddr == UDC_OFF_ADDR |=> regRdata == {25'h0, functionAddress})
        else $error("address readback wrong");
    a_regulator_readback: assert property (regRead && regAddr == UDC_OFF_CFG |=> regRdata[31] == cfg.regulator_enable)
        else $error("regulator bit wrong");
    a_cfg_readback: assert property (regRead && regAddr == UDC_OFF_CFG |=> regRdata[28] == cfg.serial_engine_enable
        && regRdata[3:0] == cfg.endpoint_direction) else $error("config readback wrong");
    a_phy_sleep: assert property (lowPower && $past(lowPower) |-> !cfg.transceiver_enable)
        else $error("transceiver on in sleep");
    a_clear_reads_zero: assert property (regRead && regAddr == UDC_OFF_CLEAR |=> regRdata == 32'h0)
        else $error("clear register read not zero");
    a_drive_gate: assert property (!dpOe |-> !dmOe && !dpOut && !dmOut)
        else $error("bus driven while disabled");
    a_drive_level: assert property (dpOe |-> dmOe && dpOut == lineOut.dplus && dmOut == lineOut.dminus)
        else $error("driven level wrong");
    a_hs_in: assert property (epInToken && !epOutToken |=> epHandshakeOk == !$past(dirSel))
        else $error("in token handshake wrong");
    a_hs_out: assert property (epOutToken && !epInToken |=> epHandshakeOk == $past(dirSel))
        else $error("out token handshake wrong");
    c_out_ok: cover property (epOutToken ##1 epHandshakeOk);
    c_drive: cover property (dpOe && dpOut);
    c_sleep: cover property (lowPower ##1 !cfg.transceiver_enable);
endmodule
bind udc_ctrl_regs udc_ctrl_regs_monitor mon (.mclk(mclk), .rst_n(rst_n), .regAddr(regAddr), .regRead(regRead),
    .regRdata(regRdata), .lowPower(lowPower), .epInToken(epInToken), .epOutToken(epOutToken),
    .epTokenNum(epTokenNum), .epHandshakeOk(epHandshakeOk), .functionAddress(functionAddress), .cfg(cfg),
    .lineOut(lineOut), .dpOut(dpOut), .dpOe(dpOe), .dmOut(dmOut), .dmOe(dmOe));
`default_nettype wire

// *** verification/udc_ctrl_regs_test.sv ***
// bench for the usb device control registers
`timescale 1ns/1ps
`default_nettype none
module udc_ctrl_regs_test;
    import udc_pkg::*;
    logic        mclk = 1'b0, rst_n = 1'b0, regWrite = 1'b0, regRead = 1'b0, lowPower = 1'b0;
    logic        evResume = 1'b0, evSof = 1'b0, evSetupErr = 1'b0, evTimeout = 1'b0;
    logic        epInToken = 1'b0, epOutToken = 1'b0, irq, epHandshakeOk, dpOut, dpOe, dmOut, dmOe;
    logic        hDp, hDm, lineDp, lineDm;
    logic [1:0]  epTokenNum = 2'h0, mode = 2'h0;
    logic [3:0]  evAck = 4'h0, evNak = 4'h0;
    logic [5:0]  evEp0 = 6'h00;
    logic [6:0]  functionAddress;
    logic [7:0]  regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0, regRdata, rdv;
    udc_cfg_t    cfg;
    udc_line_t   lineOut;
    int          failures = 0, n_compared = 0;
    // device drive wins over the host while its enable is up
    assign lineDp = dpOe ? dpOut : hDp;
    assign lineDm = dmOe ? dmOut : hDm;
    always #4 mclk = ~mclk;
    udc_host_model host (.mclk(mclk), .rst_n(rst_n), .mode(mode), .dp(hDp), .dm(hDm));
    udc_ctrl_regs #(.RESET_CYC(4), .SUSPEND_CYC(10)) dut (.mclk(mclk), .rst_n(rst_n), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .irq(irq),
        .lineDp(lineDp), .lineDm(lineDm), .lowPower(lowPower), .evResume(evResume), .evSof(evSof),
        .evEp0(evEp0), .evSetupErr(evSetupErr), .evTimeout(evTimeout), .evAck(evAck), .evNak(evNak),
        .epInToken(epInToken), .epOutToken(epOutToken), .epTokenNum(epTokenNum), .epHandshakeOk(epHandshakeOk),
        .functionAddress(functionAddress), .cfg(cfg), .lineOut(lineOut), .dpOut(dpOut), .dpOe(dpOe),
        .dmOut(dmOut), .dmOe(dmOe));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic ntick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        regAddr  <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge mclk);
        regWrite <= 1'b0;
    endtask
    // read data lives only in the cycle after the strobe
    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge mclk);
        regRead <= 1'b0;
        #1;
        chk(regRdata, exp);
    endtask
    task automatic fire(input logic on);
        @(posedge mclk);
        {evResume, evSof, evSetupErr, evTimeout} <= {4{on}};
        {evEp0, evAck, evNak} <= {14{on}};
    endtask
    task automatic t_regs();
        rc(UDC_OFF_CFG, UDC_CFG_RESET);
        rc(UDC_OFF_ADDR, 32'h0);
        rc(UDC_OFF_LINE, 32'h0);
        wr(UDC_OFF_ADDR, 32'hffffffff);
        rc(UDC_OFF_ADDR, 32'h7f);
        chk(functionAddress, 7'h7f);
        rc(8'h20, 32'h0);
        $display("register test done");
    endtask
    task automatic t_flags();
        logic [31:0] exp;
        @(posedge mclk) mode <= 2'd2;
        ntick(12);
        @(posedge mclk) mode <= 2'd0;
        fire(1'b1);
        fire(1'b0);
        exp = UDC_CLEAR_MASK;
        rc(UDC_OFF_STATUS, exp);
        wr(UDC_OFF_MASK, 32'hffffffff);
        ntick(2);
        chk(irq, 1'b1);
        wr(UDC_OFF_CLEAR, 32'h0);
        rc(UDC_OFF_STATUS, exp);
        rc(UDC_OFF_CLEAR, 32'h0);
        for (int i = 0; i < 32; i++) begin
            if (UDC_CLEAR_MASK[i]) begin
                wr(UDC_OFF_CLEAR, 32'h1 << i);
                exp[i] = 1'b0;
                rc(UDC_OFF_STATUS, exp);
            end
        end
        ntick(2);
        chk(irq, 1'b0);
        @(posedge mclk);
        evSof    <= 1'b1;
        regAddr  <= UDC_OFF_CLEAR;
        regWdata <= 32'h1 << UDC_BIT_SOF;
        regWrite <= 1'b1;
        @(posedge mclk);
        evSof    <= 1'b0;
        regWrite <= 1'b0;
        rc(UDC_OFF_STATUS, 32'h1 << UDC_BIT_SOF);
        @(posedge mclk) mode <= 2'd1;
        ntick(20);
        @(posedge mclk) mode <= 2'd0;
        wr(UDC_OFF_CLEAR, 32'hffffffff);
        rc(UDC_OFF_STATUS, 32'h1 << UDC_BIT_SUSPEND);
        wr(UDC_OFF_MASK, 32'h0);
        ntick(2);
        chk(irq, 1'b0);
        $display("flag test done");
    endtask
    // mid-run reset: suspend has no clear bit, so only reset drops it
    task automatic t_reset();
        @(posedge mclk) rst_n <= 1'b0;
        ntick(2);
        chk(regRdata, 32'h0);
        @(posedge mclk) rst_n <= 1'b1;
        rc(UDC_OFF_STATUS, 32'h0);
        rc(UDC_OFF_CFG, UDC_CFG_RESET);
        chk(cfg, 10'h200);
        chk(functionAddress, 7'h00);
        $display("reset test done");
    endtask
    task automatic t_cfg();
        logic [3:0] dir;
        dir = 4'h5;
        wr(UDC_OFF_CFG, 32'hffffffff);
        rc(UDC_OFF_CFG, UDC_CFG_WMASK);
        chk(cfg, 10'h3ff);
        @(posedge mclk) lowPower <= 1'b1;
        ntick(2);
        chk(cfg.transceiver_enable, 1'b0);
        @(posedge mclk) lowPower <= 1'b0;
        ntick(2);
        chk(cfg.transceiver_enable, 1'b1);
        wr(UDC_OFF_CFG, {28'h0, dir});
        ntick(2);
        chk(cfg, {6'h00, dir});
        for (int k = 0; k < 8; k++) begin
            @(posedge mclk);
            epTokenNum <= k[2:1];
            epInToken  <= ~k[0];
            epOutToken <= k[0];
            @(posedge mclk);
            epInToken  <= 1'b0;
            epOutToken <= 1'b0;
            #1;
            chk(epHandshakeOk, k[0] == dir[k[2:1]]);
        end
        $display("config test done");
    endtask
    task automatic t_line();
        wr(UDC_OFF_LINE, 32'h3);
        rc(UDC_OFF_LINE, 32'h0);
        chk({dpOe, dmOe}, 2'b00);
        wr(UDC_OFF_LINE, 32'h6);
        rc(UDC_OFF_LINE, 32'h6);
        chk(lineOut, 3'h6);
        chk({dpOe, dpOut, dmOe, dmOut, lineDp}, 5'b11101);
        wr(UDC_OFF_LINE, 32'h5);
        ntick(1);
        chk({dpOut, dmOut, lineDm}, 3'b011);
        wr(UDC_OFF_LINE, 32'h0);
        ntick(2);
        chk(dpOe, 1'b0);
        $display("line test done");
    endtask
    task automatic complete_run();
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        t_regs();
        t_flags();
        t_reset();
        t_cfg();
        t_line();
        complete_run();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        $display("mismatch at %0t: run did not finish", $time);
        complete_run();
    end
endmodule
`default_nettype wire
